// ---- include/ras_defs.vh ----
`ifndef RAS_DEFS_VH
`define RAS_DEFS_VH

// apb byte offsets
`define OFF_PTR       12'h000
`define OFF_STATUS    12'h004
`define OFF_IRQ_STAT  12'h008
`define OFF_IRQ_MASK  12'h00C
`define OFF_ENTRY0    12'h040

// pointer / status fields
`define PTR_W         4
`define PTR_RST       4'hF
`define DEPTH_W       5
`define DEPTH_MAX     5'h10
`define PC_W          14
`define HI_W          6
`define LO_W          8
`define ST_OVF_BIT    0
`define ST_EMPTY_BIT  1
`define ST_FULL_BIT   2

// interrupt events
`define IRQ_W         2
`define IRQ_OVF_BIT   0
`define IRQ_POP_EMPTY 1
`define IRQ_RST       2'h0

`endif

// ---- logic/entry_store.v ----
`timescale 1ns/1ps
`include "ras_defs.vh"

// sixteen 14-bit entries, one write port, two read ports
module entry_store (
   // clock and reset
   input  wire                  clk,
   input  wire                  rst_n,
   // write port
   input  wire                  wr_en,
   input  wire [`PTR_W-1:0]     wr_idx,
   input  wire [`PC_W-1:0]      wr_data,
   // read ports
   input  wire [`PTR_W-1:0]     rd_idx_a,
   output wire [`PC_W-1:0]      rd_data_a,
   input  wire [`PTR_W-1:0]     rd_idx_b,
   output wire [`PC_W-1:0]      rd_data_b
);

   wire [`PC_W*16-1:0] flat;

   genvar i;
   generate
      for (i = 0; i < 16; i = i + 1) begin : g_ent
         reg [`PC_W-1:0] ent_r;
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               ent_r <= {`PC_W{1'b0}};
            end else if (wr_en && wr_idx == i) begin
               ent_r <= wr_data;
            end
         end
         assign flat[i*`PC_W +: `PC_W] = ent_r;
      end
   endgenerate

   assign rd_data_a = flat[rd_idx_a*`PC_W +: `PC_W];
   assign rd_data_b = flat[rd_idx_b*`PC_W +: `PC_W];

endmodule

// ---- logic/event_sticky.v ----
`timescale 1ns/1ps
`include "ras_defs.vh"

// sticky event bits, write-one-to-clear, masked level interrupt
module event_sticky (
   // clock and reset
   input  wire                  clk,
   input  wire                  rst_n,
   // events and software clear
   input  wire [`IRQ_W-1:0]     evt,
   input  wire                  clr_en,
   input  wire [`IRQ_W-1:0]     clr_bits,
   input  wire                  mask_wr,
   input  wire [`IRQ_W-1:0]     mask_data,
   // state
   output reg  [`IRQ_W-1:0]     stat_r,
   output reg  [`IRQ_W-1:0]     mask_r,
   output wire                  irq
);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_r <= `IRQ_RST;
         mask_r <= `IRQ_RST;
      end else begin
         // a new event beats a simultaneous clear
         stat_r <= (stat_r & ~(clr_en ? clr_bits : `IRQ_RST)) | evt;
         if (mask_wr) begin
            mask_r <= mask_data;
         end
      end
   end

   assign irq = |(stat_r & mask_r);

endmodule

// ---- logic/return_address_stack.v ----
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "ras_defs.vh"

module return_address_stack (
   // clock and system reset
   input  wire                  CLOCK,
   input  wire                  RESET_N,
   // sequencer side
   input  wire                  PUSH,
   input  wire [`PC_W-1:0]      PUSH_PC,
   input  wire                  POP,
   output reg  [`PC_W-1:0]      POP_PC,
   output reg                   POP_VALID,
   // apb slave
   input  wire                  PSEL,
   input  wire                  PENABLE,
   input  wire                  PWRITE,
   input  wire [11:0]           PADDR,
   input  wire [31:0]           PWDATA,
   output reg  [31:0]           PRDATA,
   output wire                  PREADY,
   output wire                  PSLVERR,
   // interrupt
   output wire                  IRQ
);

   reg  [`PTR_W-1:0]   ptr_r;
   reg  [`PTR_W-1:0]   ptr_nxt;
   reg  [`DEPTH_W-1:0] depth_r;
   reg  [`DEPTH_W-1:0] depth_nxt;
   reg                 ovf_r;
   reg                 do_store;
   reg                 ovf_evt;
   reg                 pop_empty_evt;
   reg                 mapped;
   reg  [31:0]         rdata_nxt;

   wire                apb_acc;
   wire                apb_wr;
   wire                apb_rd;
   wire                ptr_wr;
   wire                entry_hit;
   wire [`PTR_W-1:0]   entry_idx;
   wire [`PTR_W-1:0]   top_idx;
   wire [`PC_W-1:0]    top_pc;
   wire [`PC_W-1:0]    sw_pc;
   wire [`IRQ_W-1:0]   irq_stat;
   wire [`IRQ_W-1:0]   irq_mask;
   wire [`PC_W-1:0]    rd_entry;
   wire                rd_setup;

   assign apb_acc   = PSEL & PENABLE;
   assign apb_wr    = apb_acc & PWRITE;
   assign apb_rd    = apb_acc & ~PWRITE;
   assign PREADY    = 1'b1;
   assign PSLVERR   = apb_acc & ~mapped;
   assign ptr_wr    = apb_wr && PADDR == `OFF_PTR;
   assign entry_hit = PADDR[11:6] == `OFF_ENTRY0 >> 6;
   assign entry_idx = PADDR[5:2];
   // depth k holds its address in entry k-1, so the top is depth-1
   assign top_idx   = depth_r[`PTR_W-1:0] - 4'h1;
   // read data is loaded in the setup cycle so it stands in the access
   assign rd_setup  = PSEL & ~PENABLE & ~PWRITE;

   // stack movement; a push and pop together are treated as a push
   always @* begin
      ptr_nxt       = ptr_r;
      depth_nxt     = depth_r;
      do_store      = 1'b0;
      ovf_evt       = 1'b0;
      pop_empty_evt = 1'b0;
      if (PUSH) begin
         if (depth_r == `DEPTH_MAX) begin
            // no slot left: flag and park pointer one below F
            ptr_nxt = `PTR_RST - 4'h1;
            ovf_evt = 1'b1;
         end else begin
            ptr_nxt   = ptr_r - 4'h1;
            depth_nxt = depth_r + 5'h01;
            do_store  = 1'b1;
         end
      end else if (POP) begin
         if (depth_r == {`DEPTH_W{1'b0}}) begin
            // underflow: nothing to return, leave state alone
            pop_empty_evt = 1'b1;
         end else begin
            ptr_nxt   = ptr_r + 4'h1;
            depth_nxt = depth_r - 5'h01;
         end
      end else if (ptr_wr) begin
         // software may move the pointer; depth follows so empty stays F
         ptr_nxt   = PWDATA[`PTR_W-1:0];
         depth_nxt = {1'b0, `PTR_RST - PWDATA[`PTR_W-1:0]};
      end
   end

   always @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         ptr_r     <= `PTR_RST;
         depth_r   <= {`DEPTH_W{1'b0}};
         ovf_r     <= 1'b0;
         POP_PC    <= {`PC_W{1'b0}};
         POP_VALID <= 1'b0;
         PRDATA    <= 32'h0000_0000;
      end else begin
         ptr_r   <= ptr_nxt;
         depth_r <= depth_nxt;
         // no software path reaches this flag
         if (ovf_evt) begin
            ovf_r <= 1'b1;
         end
         POP_VALID <= POP & ~PUSH & (depth_r != {`DEPTH_W{1'b0}});
         if (POP && !PUSH && depth_r != {`DEPTH_W{1'b0}}) begin
            POP_PC <= top_pc;
         end
         if (rd_setup) begin
            PRDATA <= rdata_nxt;
         end
      end
   end

   entry_store u_store (
      .clk       (CLOCK),
      .rst_n     (RESET_N),
      // push writes slot depth_r; the sequencer hands the stacked opcode pc
      .wr_en     (do_store | (apb_wr & entry_hit & ~PUSH)),
      .wr_idx    (do_store ? depth_r[`PTR_W-1:0] : entry_idx),
      .wr_data   (do_store ? PUSH_PC : sw_pc),
      .rd_idx_a  (top_idx),
      .rd_data_a (top_pc),
      .rd_idx_b  (entry_idx),
      .rd_data_b (rd_entry)
   );

   // software entry writes: upper part in bits 13:8, lower in 7:0
   assign sw_pc = PWDATA[`PC_W-1:0];

   event_sticky u_evt (
      .clk       (CLOCK),
      .rst_n     (RESET_N),
      .evt       ({pop_empty_evt, ovf_evt}),
      .clr_en    (apb_wr && PADDR == `OFF_IRQ_STAT),
      .clr_bits  (PWDATA[`IRQ_W-1:0]),
      .mask_wr   (apb_wr && PADDR == `OFF_IRQ_MASK),
      .mask_data (PWDATA[`IRQ_W-1:0]),
      .stat_r    (irq_stat),
      .mask_r    (irq_mask),
      .irq       (IRQ)
   );

   // read mux and decode
   always @* begin
      rdata_nxt = 32'h0000_0000;
      mapped    = 1'b1;
      if (entry_hit) begin
         rdata_nxt[`PC_W-1:0] = rd_entry;
      end else begin
         case (PADDR)
            `OFF_PTR: begin
               rdata_nxt[`PTR_W-1:0] = ptr_r;
            end
            `OFF_STATUS: begin
               rdata_nxt[`ST_OVF_BIT]   = ovf_r;
               rdata_nxt[`ST_EMPTY_BIT] = depth_r == {`DEPTH_W{1'b0}};
               rdata_nxt[`ST_FULL_BIT]  = depth_r == `DEPTH_MAX;
               rdata_nxt[11:8]          = depth_r[3:0];
               rdata_nxt[12]            = depth_r[4];
            end
            `OFF_IRQ_STAT: begin
               rdata_nxt[`IRQ_W-1:0] = irq_stat;
            end
            `OFF_IRQ_MASK: begin
               rdata_nxt[`IRQ_W-1:0] = irq_mask;
            end
            default: begin
               mapped = 1'b0;
            end
         endcase
      end
   end

endmodule

// ---- verif/ras_props.sv ----
`timescale 1ns/1ps
module ras_props (
   // clock and reset
   input wire        CLOCK,
   input wire        RESET_N,
   // sequencer side
   input wire        PUSH,
   input wire        POP,
   input wire [13:0] POP_PC,
   input wire        POP_VALID,
   // apb
   input wire        PSEL,
   input wire        PENABLE,
   input wire        PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   input wire [31:0] PRDATA,
   input wire        PREADY,
   input wire        PSLVERR
);
   reg  [4:0] depth_r;
   wire       acc = PSEL & PENABLE;
   wire       mapped = PADDR < 12'h010 || PADDR[11:6] == 6'h01;
   // own depth copy, so full and empty differ though the pointer agrees
   always @(posedge CLOCK or negedge RESET_N)
      if (!RESET_N)
         depth_r <= 5'h00;
      else if (PUSH)
         depth_r <= (depth_r == 5'h10) ? depth_r : depth_r + 5'h01;
      else if (POP && depth_r != 5'h00)
         depth_r <= depth_r - 5'h01;
      else if (acc && PWRITE && PADDR == 12'h000)
         depth_r <= 5'h0F - {1'b0, PWDATA[3:0]};
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);
   chk_empty_pop: assert property (
      POP && !PUSH && depth_r == 5'h00 |=> !POP_VALID)
      else $error("pop at empty gave data");
   chk_pop_gives: assert property (
      POP && !PUSH && depth_r != 5'h00 |=> POP_VALID)
      else $error("pop gave no data");
   chk_no_pop: assert property (
      !POP || PUSH |=> !POP_VALID) else $error("data without pop");
   chk_pc_stands: assert property (
      !POP_VALID |-> $stable(POP_PC)) else $error("pop pc moved");
   chk_ready_high: assert property (
      PSEL |-> PREADY) else $error("ready low");
   chk_err_decode: assert property (
      acc |-> PSLVERR == !mapped) else $error("bad error reply");
   chk_err_idle: assert property (
      !acc |-> !PSLVERR) else $error("error outside access");
   chk_rdata_holds: assert property (
      !(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA))
      else $error("read data moved");
endmodule
bind return_address_stack ras_props i_ras_props (.CLOCK(CLOCK),
   .RESET_N(RESET_N), .PUSH(PUSH), .POP(POP), .POP_PC(POP_PC),
   .POP_VALID(POP_VALID), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR));

// ---- verif/seq_model.sv ----
`timescale 1ns/1ps
// op: 1 call, 2 interrupt entry, 3 return, 4 return from interrupt
module seq_model (
   // instruction issued
   input  wire [2:0]  op,
   input  wire [13:0] pc,
   // stack requests
   output wire        push,
   output wire [13:0] push_pc,
   output wire        pop
);
   assign push    = op == 3'h1 || op == 3'h2;
   assign pop     = op == 3'h3 || op == 3'h4;
   // no stale value between pushes
   assign push_pc = push ? pc : ~pc;
endmodule

// ---- verif/tb_return_address_stack.sv ----
`timescale 1ns/1ps
module tb_return_address_stack;
   reg         clock, reset_n, psel, penable, pwrite, err;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd;
   reg  [2:0]  op;
   reg  [13:0] pc;
   wire        push, pop, pop_valid, pready, pslverr, irq;
   wire [13:0] push_pc, pop_pc;
   wire [31:0] prdata;
   integer     num_errors, compares, cycles, k;
   seq_model i_seq_model (.op(op), .pc(pc), .push(push), .push_pc(push_pc),
      .pop(pop));
   return_address_stack i_return_address_stack (.CLOCK(clock),
      .RESET_N(reset_n), .PUSH(push), .PUSH_PC(push_pc), .POP(pop),
      .POP_PC(pop_pc), .POP_VALID(pop_valid), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task check(input [31:0] seen, input [31:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch %0t seen %h want %h", $time, seen, exp);
         end
      end
   endtask
   task apb(input wr, input [11:0] a, input [31:0] d);
      begin
         @(posedge clock);
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge clock);
         penable <= 1'b1;
         @(posedge clock);
         while (pready !== 1'b1)
            @(posedge clock);
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         rd = prdata;
      end
   endtask
   task rdchk(input [11:0] a, input [31:0] exp);
      begin
         apb(1'b0, a, 32'h0);
         check(rd, exp);
      end
   endtask
   task step(input [2:0] o, input [13:0] p);
      begin
         @(posedge clock);
         op <= o;
         pc <= p;
         @(posedge clock);
         op <= 3'h0;
         #1;
      end
   endtask
   task wrap_up;
      begin
         if (num_errors == 0 && compares > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   initial begin
      cycles = 0;
      while (cycles < 5000) begin
         @(posedge clock);
         cycles = cycles + 1;
      end
      num_errors = num_errors + 1;
      wrap_up;
   end
   initial begin
      num_errors = 0;
      compares = 0;
      {psel, penable, pwrite, paddr, pwdata, op, pc} = 0;
      reset_n = 1'b0;
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      rdchk(12'h000, 32'hF);
      rdchk(12'h004, 32'h2);
      apb(1'b1, 12'h00C, 32'h1);
      for (k = 0; k < 16; k = k + 1) begin
         step(3'h1 + k[0], {10'h2A0, k[3:0]});
         rdchk(12'h000, (32'hE - k) & 32'hF);
         rdchk(12'h040 | {k[3:0], 2'h0}, {10'h2A0, k[3:0]});
      end
      rdchk(12'h004, 32'h1004);
      for (k = 15; k >= 0; k = k - 1) begin
         step(3'h3 + k[0], 14'h0);
         check(pop_valid, 1'b1);
         check(pop_pc, {10'h2A0, k[3:0]});
         rdchk(12'h000, 32'hF - k);
      end
      step(3'h4, 14'h0);
      check(pop_valid, 1'b0);
      check(irq, 1'b0);
      rdchk(12'h008, 32'h2);
      apb(1'b1, 12'h008, 32'h2);
      rdchk(12'h008, 32'h0);
      for (k = 0; k < 16; k = k + 1)
         step(3'h2, 14'h1111);
      step(3'h1, 14'h3FFF);
      check(irq, 1'b1);
      rdchk(12'h000, 32'hE);
      rdchk(12'h004, 32'h1005);
      rdchk(12'h07C, 32'h1111);
      apb(1'b1, 12'h004, 32'h0);
      rdchk(12'h004, 32'h1005);
      apb(1'b1, 12'h008, 32'h1);
      step(3'h0, 14'h0);
      check(irq, 1'b0);
      rdchk(12'h020, 32'h0);
      check(err, 1'b1);
      @(posedge clock);
      reset_n <= 1'b0;
      @(posedge clock);
      reset_n <= 1'b1;
      rdchk(12'h004, 32'h2);
      apb(1'b1, 12'h000, 32'h7);
      rdchk(12'h000, 32'h7);
      rdchk(12'h004, 32'h800);
      wrap_up;
   end
endmodule
